// >>> design/twm_top.sv
`timescale 1ns/1ps
`include "twm_consts.svh"

module twm_fifo #(
    parameter int WIDTH = `TWM_FIFO_W,
    parameter int DEPTH = `TWM_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // Handshakes and occupancy
    assign push       = in_valid && in_ready;
    assign pop        = out_valid && out_ready;
    assign next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
    assign out_data   = mem[rd_ptr];

    // Storage
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end

    // Pointers and registered full/empty
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= wr_ptr + AW'(push);
            rd_ptr    <= rd_ptr + AW'(pop);
            count     <= next_count;
            in_ready  <= next_count != (AW + 1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule : twm_fifo

module twm_top
    import twm_pkg::*;
#(
    parameter int FIFO_DEPTH = `TWM_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Software control and strobes
    input  wire twm_ctrl_t  ctrl,
    input  wire logic       start_cmd,
    input  wire logic       stop_cmd,
    input  wire logic       sr1_read,
    input  wire logic       sr2_read,
    input  wire logic       dr_read,
    input  wire logic       dr_write,
    input  wire logic [7:0] dr_wdata,
    output logic            dr_wready,
    // Software status
    output twm_stat_t       status,
    output logic [7:0]      dr_rdata,
    output logic            irq,
    // Bus pins
    input  wire logic       sda_in,
    input  wire logic       scl_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            scl_out,
    output logic            scl_oe,
    // Port logic used while disabled
    input  wire logic       gpio_sda_out,
    input  wire logic       gpio_sda_oe,
    input  wire logic       gpio_scl_out,
    input  wire logic       gpio_scl_oe
);
    twm_state_t           state;
    logic [3:0]           bit_cnt;
    logic [7:0]           shreg;
    logic [`TWM_DIV_W-1:0] div_cnt;
    logic                 xmit, need_rd, sr1_seen, addr2, addressed, busy, master;
    logic                 sda_low, hold, mst_low, mst_first, rd_bit, nack;
    logic                 ev_address_matched_flag, ev_hdr;
    logic                 address_matched_flag, byte_transfer_finished_flag, stop_detected_flag, sb, arlo;
    logic                 fifo_v;
    logic                 pop;
    logic [7:0]           fifo_d;

    // Transmit bytes wait here; the engine drains one per release
    twm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (dr_write),
        .in_ready  (dr_wready),
        .in_data   (dr_wdata),
        .out_valid (fifo_v),
        .out_ready (pop),
        .out_data  (fifo_d)
    );

    // Pin synchronisers with agreement filter
    logic       pin_in [2];
    logic [2:0] syn    [2];
    logic       filt   [2];
    logic       filt_d [2];
    assign pin_in[0] = sda_in;
    assign pin_in[1] = scl_in;
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                syn[g]    <= 3'h7;
                filt[g]   <= 1'b1;
                filt_d[g] <= 1'b1;
            end else begin
                syn[g] <= {syn[g][1:0], pin_in[g]};
                if (syn[g][1] == syn[g][2]) filt[g] <= syn[g][2];
                filt_d[g] <= filt[g];
            end
        end
    end

    // Bus events
    wire sda       = filt[0];
    wire scl       = filt[1];
    wire scl_rise  = scl && !filt_d[1];
    wire scl_fall  = !scl && filt_d[1];
    wire start_det = scl && filt_d[1] && !sda && filt_d[0];
    wire stop_det  = scl && filt_d[1] && sda && !filt_d[0];
    wire byte_end  = scl_fall && bit_cnt == `TWM_BITS;

    // Divider half period from speed mode and divider bits
    wire [`TWM_DIV_W-1:0] half_cnt = (ctrl.fast ? `TWM_DIV_W'(`TWM_FAST_HALF) : `TWM_DIV_W'(`TWM_STD_HALF))
                                   + {1'b0, ctrl.div, 3'h0};
    wire tick = div_cnt == '0;

    // Address decode
    wire hdr_hit  = ctrl.addr10 && shreg[7:3] == `TWM_HDR10 && shreg[2:1] == ctrl.own_addr[9:8];
    wire own7_hit = !ctrl.addr10 && shreg[7:1] == ctrl.own_addr[6:0];
    wire gc_hit   = ctrl.gcall_en && shreg == `TWM_GCALL;
    wire hdr_rd   = hdr_hit && shreg[0] && addressed && !addr2;
    wire hdr_wr   = hdr_hit && !shreg[0] && !addr2;
    wire full_hit = (addr2 && shreg == ctrl.own_addr[7:0]) || hdr_rd || (!addr2 && (own7_hit || gc_hit));
    wire any_hit  = full_hit || hdr_wr;

    // Hold release and buffer pop
    wire release_ok = sr1_seen && (xmit ? fifo_v : (!need_rd || dr_read));
    assign pop      = ctrl.enable && state == ST_HOLD && !(stop_cmd && master) && release_ok && xmit;
    wire toggle_st  = state == ST_TX || state == ST_RX || state == ST_ACK || state == ST_GETACK;

    // Divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) div_cnt <= '0;
        else if (tick) div_cnt <= half_cnt - `TWM_DIV_W'(1);
        else div_cnt <= div_cnt - `TWM_DIV_W'(1);
    end

    // Byte engine, role and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            {bit_cnt, shreg, dr_rdata} <= '0;
            {xmit, need_rd, sr1_seen, addr2, addressed, busy, master} <= '0;
            {sda_low, hold, mst_low, mst_first, rd_bit, nack, ev_address_matched_flag, ev_hdr} <= '0;
            {address_matched_flag, byte_transfer_finished_flag, stop_detected_flag, sb, arlo} <= '0;
        end else begin
            if (sr1_read) begin
                address_matched_flag <= 1'b0;
                sb   <= 1'b0;
                if (state == ST_HOLD) sr1_seen <= 1'b1;
            end
            if (sr2_read) begin
                stop_detected_flag <= 1'b0;
                arlo  <= 1'b0;
            end
            if (master && tick && toggle_st) mst_low <= !mst_low;
            if (!ctrl.enable) begin
                state <= ST_IDLE;
                {master, hold, sda_low, mst_low, busy, addressed} <= '0;
            end else if (stop_det) begin
                if (addressed && !master) stop_detected_flag <= 1'b1;
                state <= ST_IDLE;
                {master, hold, sda_low, mst_low, busy, addressed} <= '0;
            end else if (start_det && state != ST_START) begin
                state   <= ST_ADDR;
                busy    <= 1'b1;
                bit_cnt <= '0;
                {addr2, hold, sda_low} <= '0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (start_cmd && !busy) begin
                            state   <= ST_START;
                            master  <= 1'b1;
                            mst_low <= 1'b0;
                        end
                    end
                    ST_START: begin
                        if (start_det) begin
                            state     <= ST_HOLD;
                            {hold, xmit, sb, busy, mst_first} <= '1;
                            need_rd   <= 1'b0;
                        end else if (tick) begin
                            sda_low <= 1'b1;
                        end
                    end
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_end) begin
                            dr_rdata <= shreg;
                            if (state == ST_RX) begin
                                state   <= ST_ACK;
                                sda_low <= ctrl.ack_en;
                                {ev_address_matched_flag, ev_hdr} <= '0;
                            end else if (any_hit) begin
                                state     <= ST_ACK;
                                sda_low   <= ctrl.ack_en;
                                ev_address_matched_flag   <= 1'b1;
                                ev_hdr    <= !full_hit;
                                xmit      <= hdr_rd || (own7_hit && shreg[0]);
                                addressed <= addressed || full_hit;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (master && !sda_low && !sda) begin
                                state   <= ST_IDLE;
                                master  <= 1'b0;
                                arlo    <= 1'b1;
                                mst_low <= 1'b0;
                            end
                        end
                        if (byte_end) begin
                            state   <= ST_GETACK;
                            sda_low <= 1'b0;
                        end else if (scl_fall) begin
                            shreg   <= {shreg[6:0], 1'b0};
                            sda_low <= !shreg[6];
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_low <= 1'b0;
                            bit_cnt <= '0;
                            if (ev_hdr) begin
                                state <= ST_ADDR;
                                addr2 <= 1'b1;
                            end else begin
                                state   <= ST_HOLD;
                                hold    <= 1'b1;
                                need_rd <= !ev_address_matched_flag;
                                if (ev_address_matched_flag) address_matched_flag <= 1'b1;
                                else byte_transfer_finished_flag <= 1'b1;
                            end
                        end
                    end
                    ST_GETACK: begin
                        if (scl_rise) nack <= sda;
                        if (scl_fall) begin
                            bit_cnt <= '0;
                            if (nack && !master) begin
                                state <= ST_IDLE;
                            end else begin
                                state     <= ST_HOLD;
                                hold      <= 1'b1;
                                need_rd   <= 1'b0;
                                byte_transfer_finished_flag       <= !nack;
                                mst_first <= 1'b0;
                                if (mst_first) xmit <= !rd_bit;
                            end
                        end
                    end
                    ST_HOLD: begin
                        if (stop_cmd && master) begin
                            state   <= ST_STOP;
                            {sda_low, mst_low} <= '1;
                            hold    <= 1'b0;
                        end else if (release_ok) begin
                            state    <= xmit ? ST_TX : ST_RX;
                            {hold, sr1_seen, byte_transfer_finished_flag} <= '0;
                            bit_cnt  <= '0;
                            mst_low  <= 1'b1;
                            shreg    <= fifo_d;
                            sda_low  <= xmit && !fifo_d[7];
                            if (mst_first) rd_bit <= fifo_d[0];
                        end
                    end
                    ST_STOP: begin
                        if (tick) begin
                            if (mst_low) mst_low <= 1'b0;
                            else sda_low <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Status, request and pins; disabled hands pins to port logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status  <= '0;
            irq     <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end else begin
            status  <= '{event_f: address_matched_flag | byte_transfer_finished_flag | stop_detected_flag | sb | arlo, address_matched_flag: address_matched_flag, byte_transfer_finished_flag: byte_transfer_finished_flag, stop_detected_flag: stop_detected_flag,
                         sb: sb, arlo: arlo, master: master, xmit: xmit, busy: busy};
            irq     <= ctrl.int_en && (address_matched_flag | byte_transfer_finished_flag | stop_detected_flag | sb | arlo);
            sda_out <= ctrl.enable ? 1'b0 : gpio_sda_out;
            sda_oe  <= ctrl.enable ? sda_low : gpio_sda_oe;
            scl_out <= ctrl.enable ? 1'b0 : gpio_scl_out;
            scl_oe  <= ctrl.enable ? (hold || (master && mst_low)) : gpio_scl_oe;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_rx_end;
        state == ST_RX && byte_end && !stop_det && !start_det && ctrl.enable;
    endsequence
    sequence s_addr_miss;
        state == ST_ADDR && byte_end && !any_hit && !stop_det && !start_det && ctrl.enable;
    endsequence

    property p_stop_slave;
        stop_det && ctrl.enable |=> !master ##1 !status.master;
    endproperty
    a_stop_slave: assert property (p_stop_slave) else $error("still master after stop");

    property p_hold_pin;
        state == ST_HOLD && ctrl.enable |=> scl_oe;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("clock not held low");

    property p_rx_wait;
        state == ST_HOLD && !xmit && need_rd && !dr_read && !stop_cmd && !stop_det && !start_det
            && ctrl.enable |=> state == ST_HOLD;
    endproperty
    a_rx_wait: assert property (p_rx_wait) else $error("released before data read");

    property p_gpio;
        !ctrl.enable |=> sda_oe == $past(gpio_sda_oe) && scl_oe == $past(gpio_scl_oe);
    endproperty
    a_gpio: assert property (p_gpio) else $error("pins not handed to port logic");

    property p_address_matched_flag_event;
        $rose(address_matched_flag) |=> status.event_f && status.address_matched_flag;
    endproperty
    a_address_matched_flag_event: assert property (p_address_matched_flag_event) else $error("match event missing");

    property p_miss_idle;
        s_addr_miss |=> state == ST_IDLE && !address_matched_flag;
    endproperty
    a_miss_idle: assert property (p_miss_idle) else $error("unmatched address not ignored");

    property p_rx_ack;
        s_rx_end |=> state == ST_ACK && sda_low == $past(ctrl.ack_en);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("acknowledge not driven");

    property p_tx_msb;
        state == ST_TX && scl_fall && bit_cnt < `TWM_BITS && !stop_det && !start_det && ctrl.enable
            |=> sda_low == !$past(shreg[6]);
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("wrong bit order");

    property p_stop_detected_flag;
        stop_det && addressed && !master && ctrl.enable |=> stop_detected_flag;
    endproperty
    a_stop_detected_flag: assert property (p_stop_detected_flag) else $error("stop flag not set");
endmodule : twm_top

// >>> design/twm_consts.svh
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH
// System clock and bus speed limits
`define TWM_CLK_KHZ    250000
`define TWM_STD_KHZ    100
`define TWM_FAST_KHZ   400
// Least half period in cycles, rounded up
`define TWM_STD_HALF   ((`TWM_CLK_KHZ + 2 * `TWM_STD_KHZ - 1) / (2 * `TWM_STD_KHZ))
`define TWM_FAST_HALF  ((`TWM_CLK_KHZ + 2 * `TWM_FAST_KHZ - 1) / (2 * `TWM_FAST_KHZ))
`define TWM_DIV_W      12
// Byte framing and addresses
`define TWM_BITS       4'h8
`define TWM_HDR10      5'h1e
`define TWM_GCALL      8'h00
// Transmit buffer
`define TWM_FIFO_W     8
`define TWM_FIFO_DEPTH 16
`endif

// >>> design/twm_pkg.sv
package twm_pkg;
    // Software control bits
    typedef struct packed {
        logic       enable;
        logic       ack_en;
        logic       gcall_en;
        logic       int_en;
        logic       fast;
        logic       addr10;
        logic [9:0] own_addr;
        logic [7:0] div;
    } twm_ctrl_t;
    // Status bits
    typedef struct packed {
        logic event_f;
        logic address_matched_flag;
        logic byte_transfer_finished_flag;
        logic stop_detected_flag;
        logic sb;
        logic arlo;
        logic master;
        logic xmit;
        logic busy;
    } twm_stat_t;
    // Byte engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_ADDR, ST_RX, ST_TX, ST_ACK, ST_GETACK, ST_HOLD, ST_STOP
    } twm_state_t;
endpackage : twm_pkg

// >>> tb/twm_bus_master.sv
`timescale 1ns/1ps
module twm_bus_master #(
    parameter int HALF = 20
) (
    // Clock
    input  wire logic clk,
    // Wired bus levels
    input  wire logic scl,
    input  wire logic sda,
    // Open-drain pulls, high means released
    output logic      m_scl,
    output logic      m_sda
);
    int stall;

    // Both lines released at power-up
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end

    // Release clock, wait out a stretch by the slave of up to 20000 cycles, then hold high
    task automatic rise();
        m_scl = 1'b1;
        stall = 0;
        while (scl !== 1'b1 && stall < 20000) begin
            @(negedge clk);
            stall++;
        end
        repeat (HALF) @(negedge clk);
    endtask : rise

    // One clock pulse; data changes only while clock is low
    task automatic pulse(input logic d, output logic smp);
        repeat (4) @(negedge clk);
        m_sda = d;
        repeat (HALF) @(negedge clk);
        rise();
        smp = sda;
        m_scl = 1'b0;
    endtask : pulse

    // Start: data falls while clock is high
    task automatic start();
        m_sda = 1'b1;
        m_scl = 1'b1;
        repeat (HALF) @(negedge clk);
        m_sda = 1'b0;
        repeat (HALF) @(negedge clk);
        m_scl = 1'b0;
    endtask : start

    // Stop: data rises while clock is high
    task automatic stop();
        repeat (4) @(negedge clk);
        m_sda = 1'b0;
        repeat (HALF) @(negedge clk);
        rise();
        m_sda = 1'b1;
        repeat (HALF) @(negedge clk);
    endtask : stop

    // Byte of eight pulses MSB first, then the acknowledge pulse
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx, output logic ack);
        for (int b = 7; b >= 0; b--) begin
            pulse(tx[b], rx[b]);
        end
        pulse(ninth, ack);
    endtask : xfer
endmodule : twm_bus_master

// >>> tb/two_wire_multimaster_slave_interface_tb_top.sv
`timescale 1ns/1ps
module two_wire_multimaster_slave_interface_tb_top
    import twm_pkg::*;
;
    logic       clk, rst, start_cmd, stop_cmd, sr1_read, sr2_read, dr_read, dr_write;
    logic [7:0] dr_wdata, dr_rdata, rx, d;
    logic       dr_wready, irq, sda_out, sda_oe, scl_out, scl_oe, a, m_scl, m_sda;
    logic [3:0] gp;
    wire        scl, sda;
    twm_ctrl_t  ctrl;
    twm_stat_t  status;
    int         bad_count, comparisons, seed, n, i, k;
    logic [7:0] q[$];

    // Wired-AND bus with pull-ups
    assign scl = m_scl & ~(scl_oe & ~scl_out);
    assign sda = m_sda & ~(sda_oe & ~sda_out);

    twm_top dut (
        .clk(clk), .rst(rst), .ctrl(ctrl), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .sr1_read(sr1_read), .sr2_read(sr2_read), .dr_read(dr_read), .dr_write(dr_write),
        .dr_wdata(dr_wdata), .dr_wready(dr_wready), .status(status), .dr_rdata(dr_rdata), .irq(irq),
        .sda_in(sda), .scl_in(scl), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
        .gpio_sda_out(gp[3]), .gpio_sda_oe(gp[2]), .gpio_scl_out(gp[1]), .gpio_scl_oe(gp[0])
    );
    twm_bus_master bus (.clk(clk), .scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One-cycle software access pulse, then let flags settle
    task automatic sw(input logic [2:0] v);
        {sr1_read, dr_read, sr2_read} = v;
        @(negedge clk);
        {sr1_read, dr_read, sr2_read} = 3'h0;
        repeat (9) @(negedge clk);
    endtask : sw

    // Start plus address byte; acknowledge and match flag as expected
    task automatic addr(input logic [7:0] b, input logic hit);
        bus.start();
        bus.xfer(b, 1'b1, rx, a);
        repeat (10) @(negedge clk);
        check({7'h0, a}, {7'h0, ~hit});
        check({7'h0, status.address_matched_flag}, {7'h0, hit});
    endtask : addr

    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run

    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Watchdog against a hung bus
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        seed = 32'hf3e4;
        rst = 1'b1;
        {start_cmd, stop_cmd, sr1_read, sr2_read, dr_read, dr_write} = 6'h0;
        dr_wdata = 8'h00;
        bad_count = 0;
        comparisons = 0;
        ctrl = '0;
        ctrl.enable = 1'b1;
        ctrl.ack_en = 1'b1;
        ctrl.int_en = 1'b1;
        ctrl.fast = 1'($random(seed));
        ctrl.div = 8'($random(seed));
        ctrl.own_addr = 10'h010 + 10'($random(seed) & 32'h3f);
        gp = 4'($random(seed));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check({7'h0, status.master}, 8'h00);
        addr({ctrl.own_addr[6:0] ^ 7'h01, 1'b0}, 1'b0);
        bus.stop();
        addr(8'h00, 1'b0);
        bus.stop();
        ctrl.gcall_en = 1'b1;
        // Receiver by own address, then by general call
        for (k = 0; k < 2; k++) begin
            addr(k ? 8'h00 : {ctrl.own_addr[6:0], 1'b0}, 1'b1);
            check({6'h0, irq, scl_oe}, 8'h03);
            sw(3'h4);
            for (i = 0; i < 2; i++) begin
                d = 8'($random(seed));
                bus.xfer(d, 1'b1, rx, a);
                repeat (10) @(negedge clk);
                check({6'h0, a, status.byte_transfer_finished_flag}, 8'h01);
                check(dr_rdata, d);
                sw(3'h4);
                check({7'h0, scl_oe}, 8'h01);
                sw(3'h2);
            end
            bus.stop();
            repeat (10) @(negedge clk);
            check({7'h0, status.stop_detected_flag}, 8'h01);
            sw(3'h1);
            check({7'h0, status.stop_detected_flag}, 8'h00);
        end
        // Ten-bit write: header acknowledged without event, then low address byte matches
        ctrl.addr10 = 1'b1;
        bus.start();
        bus.xfer({5'h1e, ctrl.own_addr[9:8], 1'b0}, 1'b1, rx, a);
        repeat (10) @(negedge clk);
        check({6'h0, a, status.address_matched_flag}, 8'h00);
        bus.xfer(ctrl.own_addr[7:0], 1'b1, rx, a);
        repeat (10) @(negedge clk);
        check({5'h0, a, status.address_matched_flag, status.xmit}, 8'h02);
        sw(3'h4);
        bus.stop();
        sw(3'h1);
        ctrl.addr10 = 1'b0;
        // Transmitter: buffer filled ahead until it refuses, then drained
        addr({ctrl.own_addr[6:0], 1'b1}, 1'b1);
        sw(3'h4);
        sw(3'h2);
        check({7'h0, dr_rdata[0]}, 8'h01);
        check({7'h0, status.xmit}, 8'h01);
        check({7'h0, scl_oe}, 8'h01);
        n = 0;
        while (dr_wready === 1'b1 && n < 40) begin
            d = 8'($random(seed));
            q.push_back(d);
            dr_wdata = d;
            dr_write = 1'b1;
            n++;
            @(negedge clk);
        end
        dr_write = 1'b0;
        check({7'h0, n == 16 || n == 17}, 8'h01);
        for (i = 0; i < n; i++) begin
            bus.xfer(8'hff, i == n - 1, rx, a);
            check(rx, q[i]);
            if (i < n - 1) begin
                repeat (10) @(negedge clk);
                check({7'h0, status.byte_transfer_finished_flag}, 8'h01);
                sw(3'h4);
            end
        end
        check({7'h0, dr_wready}, 8'h01);
        bus.stop();
        sw(3'h1);
        // Disabled cell hands pins to port logic
        ctrl.enable = 1'b0;
        for (i = 0; i < 8; i++) begin
            gp = 4'($random(seed));
            repeat (3) @(negedge clk);
            check({4'h0, sda_out, sda_oe, scl_out, scl_oe}, {4'h0, gp});
        end
        complete_run();
    end
endmodule : two_wire_multimaster_slave_interface_tb_top
